// ### design/bcs_charge_fsm.sv
`default_nettype none
`include "bcs_regs.svh"

module bcs_charge_fsm
#(
   parameter logic [`BCS_CNT_W-1:0] PRESCALE_CYCLES =
      `BCS_TICK_NS / `BCS_CLK_PERIOD_NS,
   parameter logic [`BCS_CNT_W-1:0] PREQUAL_MS  = `BCS_PREQUAL_MS,
   parameter logic [`BCS_CNT_W-1:0] FASTCHG_MS  = `BCS_FASTCHG_MS,
   parameter logic [`BCS_CNT_W-1:0] TOPOFF_MS   = `BCS_TOPOFF_MS,
   parameter logic [`BCS_CNT_W-1:0] TERM_MS     = `BCS_TERM_MS
)
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  ce,
   input  wire logic                  ironPhosphateStrap,
   input  wire logic                  sourceValidIn,
   input  wire logic                  timerSuspendIn,
   input  wire logic                  lockoutCurrentIn,
   input  wire logic                  belowInputRegIn,
   input  wire logic                  abovePrechargeIn,
   input  wire logic                  aboveTrickleIn,
   input  wire logic                  atBatteryRegIn,
   input  wire logic                  belowTopoffCurIn,
   input  wire logic                  belowRestartIn,
   input  wire logic                  overTempIn,
   output bcs_pkg::bcs_state_t        chargeState,
   output bcs_pkg::bcs_current_t      currentSel,
   output logic                       holdVoltage,
   output logic                       chargerOn,
   output logic                       inputSwitchOn,
   output logic                       batterySuppliesSys,
   output logic                       timerFault,
   output logic                       statOut,
   output logic                       statOe
);

   localparam int NSYNC = 11;
   logic [NSYNC-1:0]      syncIn;
   logic                  ironPhosphate;
   logic                  sourceValid;
   logic                  timerSuspend;
   logic                  lockoutCurrent;
   logic                  belowInputReg;
   logic                  abovePrecharge;
   logic                  aboveTrickle;
   logic                  atBatteryReg;
   logic                  belowTopoffCur;
   logic                  belowRestart;
   logic                  overTemp;
   bcs_pkg::bcs_state_t   state_q;
   bcs_pkg::bcs_state_t   state_d;
   logic                  inputOff_q;
   logic                  inputOff_d;
   logic                  inputOk;
   logic                  stateClear;
   logic                  termClear;
   logic [`BCS_CNT_W-1:0] stateMs;
   logic [`BCS_CNT_W-1:0] termMs;
   logic                  termDone;

   bcs_pkg::bcs_current_t currentSel_d;
   logic                  holdVoltage_d;
   logic                  chargerOn_d;
   logic                  statOe_d;

   // All comparator outputs are analog and asynchronous
   bcs_sync #(.WIDTH (NSYNC)) u_sync
   (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .asyncIn ({ironPhosphateStrap, sourceValidIn, timerSuspendIn,
                 lockoutCurrentIn, belowInputRegIn, abovePrechargeIn,
                 aboveTrickleIn, atBatteryRegIn, belowTopoffCurIn,
                 belowRestartIn, overTempIn}),
      .syncOut (syncIn)
   );

   assign {ironPhosphate, sourceValid, timerSuspend, lockoutCurrent,
           belowInputReg, abovePrecharge, aboveTrickle, atBatteryReg,
           belowTopoffCur, belowRestart, overTemp} = syncIn;

   // State timer, restarted on every transition and held in idle
   assign stateClear = (state_d != state_q)
                       || (state_q == bcs_pkg::BCS_IDLE);
   bcs_timer #(.PRESCALE (PRESCALE_CYCLES)) u_stateTimer
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .clear    (stateClear),
      .elapsed  (stateMs)
   );

   // Termination deglitch: any rise above threshold restarts it
   assign termClear = (state_q != bcs_pkg::BCS_CV) || !belowTopoffCur;
   bcs_timer #(.PRESCALE (PRESCALE_CYCLES)) u_termTimer
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .clear    (termClear),
      .elapsed  (termMs)
   );

   assign termDone = !termClear && (termMs >= TERM_MS);

   // Lockout latch stays until the source goes away
   always_comb
   begin
      inputOff_d = inputOff_q;
      if (lockoutCurrent && belowInputReg)
         inputOff_d = 1'b1;
      else if (!sourceValid)
         inputOff_d = 1'b0;
   end

   assign inputOk = sourceValid && !inputOff_q;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         inputOff_q <= 1'b0;
      else if (ce)
         inputOff_q <= inputOff_d;
   end

   // Shutdown first, then timer faults, then forced idle, then progression
   always_comb
   begin
      state_d = state_q;
      if (overTemp)
         state_d = bcs_pkg::BCS_SHDN;
      else if (state_q == bcs_pkg::BCS_SHDN)
         state_d = bcs_pkg::BCS_IDLE;
      else if (state_q == bcs_pkg::BCS_TFLT)
      begin
         // Suspend alone does not clear a fault
         if (!sourceValid)
            state_d = bcs_pkg::BCS_IDLE;
      end
      else if (!inputOk || timerSuspend)
         state_d = bcs_pkg::BCS_IDLE;
      else
      begin
         unique case (state_q)
            bcs_pkg::BCS_IDLE:
            begin
               // No lower voltage bound: a 0 V pack starts here too
               if (!abovePrecharge)
                  state_d = bcs_pkg::BCS_PRE;
               else if (!ironPhosphate && !aboveTrickle)
                  state_d = bcs_pkg::BCS_TRK;
               else if (atBatteryReg)
                  state_d = bcs_pkg::BCS_CV;
               else
                  state_d = bcs_pkg::BCS_CC;
            end
            bcs_pkg::BCS_PRE:
            begin
               if (stateMs >= PREQUAL_MS)
                  state_d = bcs_pkg::BCS_TFLT;
               else if (abovePrecharge && ironPhosphate)
                  state_d = bcs_pkg::BCS_CC;
               else if (abovePrecharge)
                  state_d = bcs_pkg::BCS_TRK;
            end
            bcs_pkg::BCS_TRK:
            begin
               if (stateMs >= PREQUAL_MS)
                  state_d = bcs_pkg::BCS_TFLT;
               else if (ironPhosphate)
                  state_d = bcs_pkg::BCS_CC;
               else if (!abovePrecharge)
                  state_d = bcs_pkg::BCS_PRE;
               else if (aboveTrickle)
                  state_d = bcs_pkg::BCS_CC;
            end
            bcs_pkg::BCS_CC:
            begin
               if (stateMs >= FASTCHG_MS)
                  state_d = bcs_pkg::BCS_TFLT;
               else if (atBatteryReg)
                  state_d = bcs_pkg::BCS_CV;
            end
            bcs_pkg::BCS_CV:
            begin
               if (stateMs >= FASTCHG_MS)
                  state_d = bcs_pkg::BCS_TFLT;
               else if (termDone)
                  state_d = bcs_pkg::BCS_TOP;
            end
            bcs_pkg::BCS_TOP:
            begin
               if (belowRestart)
                  state_d = bcs_pkg::BCS_CC;
               else if (stateMs >= TOPOFF_MS)
                  state_d = bcs_pkg::BCS_DONE;
            end
            bcs_pkg::BCS_DONE:
            begin
               if (belowRestart)
                  state_d = bcs_pkg::BCS_CC;
            end
            default:
               state_d = bcs_pkg::BCS_IDLE;
         endcase
      end
   end

   // Outputs decoded from the next state so they align with it
   always_comb
   begin
      currentSel_d  = bcs_pkg::BCS_I_OFF;
      holdVoltage_d = 1'b0;
      chargerOn_d   = 1'b0;
      statOe_d      = 1'b0;
      unique case (state_d)
         bcs_pkg::BCS_PRE:
            currentSel_d = bcs_pkg::BCS_I_PRE;
         bcs_pkg::BCS_TRK:
            currentSel_d = bcs_pkg::BCS_I_TRK;
         bcs_pkg::BCS_CC:
            currentSel_d = bcs_pkg::BCS_I_FAST;
         bcs_pkg::BCS_CV, bcs_pkg::BCS_TOP:
         begin
            currentSel_d  = bcs_pkg::BCS_I_FAST;
            holdVoltage_d = 1'b1;
         end
         default:
            currentSel_d = bcs_pkg::BCS_I_OFF;
      endcase
      if (currentSel_d != bcs_pkg::BCS_I_OFF)
      begin
         chargerOn_d = 1'b1;
         statOe_d    = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q            <= bcs_pkg::BCS_IDLE;
         chargeState        <= bcs_pkg::BCS_IDLE;
         currentSel         <= bcs_pkg::BCS_I_OFF;
         holdVoltage        <= 1'b0;
         chargerOn          <= 1'b0;
         inputSwitchOn      <= 1'b0;
         batterySuppliesSys <= 1'b1;
         timerFault         <= 1'b0;
         statOut            <= 1'b0;
         statOe             <= 1'b0;
      end
      else if (ce)
      begin
         state_q            <= state_d;
         chargeState        <= state_d;
         currentSel         <= currentSel_d;
         holdVoltage        <= holdVoltage_d;
         chargerOn          <= chargerOn_d;
         inputSwitchOn      <= inputOk && !inputOff_d;
         batterySuppliesSys <= state_d == bcs_pkg::BCS_IDLE;
         timerFault         <= state_d == bcs_pkg::BCS_TFLT;
         statOut            <= 1'b0;
         statOe             <= statOe_d;
      end
   end

   default clocking cb @(posedge clk iff ce);
   endclocking
   default disable iff (!reset_n);
   sequence s_calm;
      inputOk && !timerSuspend && !overTemp;
   endsequence
   sequence s_pre_timeout;
      state_q == bcs_pkg::BCS_PRE && stateMs >= PREQUAL_MS;
   endsequence
   sequence s_fast_timeout;
      (state_q == bcs_pkg::BCS_CC || state_q == bcs_pkg::BCS_CV)
      && stateMs >= FASTCHG_MS;
   endsequence
   a_input_lockout: assert property (
      lockoutCurrent && belowInputReg |=> !inputSwitchOn && inputOff_q)
      else $error("input not switched off at lockout");

   a_idle_forced: assert property (
      !overTemp && state_q != bcs_pkg::BCS_TFLT
      && (!inputOk || timerSuspend) |=> state_q == bcs_pkg::BCS_IDLE)
      else $error("invalid input did not force idle");

   a_idle_outputs: assert property (
      state_q == bcs_pkg::BCS_IDLE |-> currentSel == bcs_pkg::BCS_I_OFF
      && batterySuppliesSys && stateMs == '0 ##1 stateMs == '0)
      else $error("idle not quiet");

   a_idle_exit: assert property (
      state_q == bcs_pkg::BCS_IDLE ##1 state_q != bcs_pkg::BCS_IDLE
      |-> $past(inputOk) || $past(overTemp))
      else $error("idle left without valid input");

   a_prequal_fault: assert property (
      s_calm and s_pre_timeout |=> state_q == bcs_pkg::BCS_TFLT)
      else $error("prequalification timeout missed");

   a_iron_no_trickle: assert property (
      ironPhosphate && $past(ironPhosphate) |-> state_q != bcs_pkg::BCS_TRK)
      else $error("trickle used in iron-phosphate variant");

   a_fast_fault: assert property (
      s_calm and s_fast_timeout |=> state_q == bcs_pkg::BCS_TFLT)
      else $error("fast-charge timeout missed");

   a_topoff_entry: assert property (
      $changed(state_q) && state_q == bcs_pkg::BCS_TOP
      |-> $past(state_q) == bcs_pkg::BCS_CV && $past(termDone))
      else $error("top-off entered from wrong state");

   a_fault_hold: assert property (
      (state_q == bcs_pkg::BCS_TFLT && sourceValid && !overTemp)
      ##1 (sourceValid && !overTemp)
      |-> (state_q == bcs_pkg::BCS_TFLT && !statOe && !chargerOn) [*2])
      else $error("timer fault not held");

   a_thermal: assert property (
      overTemp |=> state_q == bcs_pkg::BCS_SHDN && !chargerOn)
      else $error("thermal shutdown not entered");

   a_done_restart: assert property (
      (state_q == bcs_pkg::BCS_DONE && belowRestart) and s_calm
      |=> state_q == bcs_pkg::BCS_CC && currentSel == bcs_pkg::BCS_I_FAST)
      else $error("done did not restart");

   a_cv_hold: assert property (
      state_q == bcs_pkg::BCS_CV |-> holdVoltage && chargerOn)
      else $error("voltage not held in constant voltage");

endmodule : bcs_charge_fsm

`default_nettype wire

// ### design/bcs_pkg.sv
`default_nettype none

package bcs_pkg;

   typedef enum logic [8:0] {
      BCS_IDLE = 9'h001,
      BCS_PRE  = 9'h002,
      BCS_TRK  = 9'h004,
      BCS_CC   = 9'h008,
      BCS_CV   = 9'h010,
      BCS_TOP  = 9'h020,
      BCS_DONE = 9'h040,
      BCS_TFLT = 9'h080,
      BCS_SHDN = 9'h100
   } bcs_state_t;

   typedef enum logic [1:0] {
      BCS_I_OFF  = 2'h0,
      BCS_I_PRE  = 2'h1,
      BCS_I_TRK  = 2'h2,
      BCS_I_FAST = 2'h3
   } bcs_current_t;

endpackage : bcs_pkg

`default_nettype wire

// ### design/bcs_regs.svh
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH

// Base clock and prescaled tick
`define BCS_CLK_PERIOD_NS 32'd8
`define BCS_TICK_NS       32'd1000000

// Timer durations in milliseconds (one tick each)
`define BCS_PREQUAL_MS    32'd1800000
`define BCS_FASTCHG_MS    32'd21600000
`define BCS_TOPOFF_MS     32'd1800000
`define BCS_TERM_MS       32'd16

// Prescaler and timer counter widths
`define BCS_CNT_W         32

`endif

// ### design/bcs_sync.sv
`default_nettype none

module bcs_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = ce ? asyncIn : meta_q;
      sync_d = ce ? meta_q : syncOut;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q  <= '0;
         syncOut <= '0;
      end
      else
      begin
         meta_q  <= meta_d;
         syncOut <= sync_d;
      end
   end

endmodule : bcs_sync

`default_nettype wire

// ### design/bcs_timer.sv
`default_nettype none
`include "bcs_regs.svh"

// Millisecond timer: prescaler plus saturating tick counter
module bcs_timer
#(
   parameter logic [`BCS_CNT_W-1:0] PRESCALE = `BCS_TICK_NS / `BCS_CLK_PERIOD_NS
)
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  ce,
   input  wire logic                  clear,
   output logic      [`BCS_CNT_W-1:0] elapsed
);

   logic [`BCS_CNT_W-1:0] pre_q;
   logic [`BCS_CNT_W-1:0] pre_d;
   logic [`BCS_CNT_W-1:0] elapsed_d;

   always_comb
   begin
      pre_d     = pre_q;
      elapsed_d = elapsed;
      if (clear)
      begin
         pre_d     = '0;
         elapsed_d = '0;
      end
      else if (pre_q >= PRESCALE - 1'b1)
      begin
         pre_d = '0;
         // Saturate so a stuck state never wraps past its limit
         if (elapsed != '1)
            elapsed_d = elapsed + 1'b1;
      end
      else
         pre_d = pre_q + 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pre_q   <= '0;
         elapsed <= '0;
      end
      else if (ce)
      begin
         pre_q   <= pre_d;
         elapsed <= elapsed_d;
      end
   end

endmodule : bcs_timer

`default_nettype wire

// ### testbench/bcs_cell_model.sv
`default_nettype none

// Cell and charge source seen through their comparators
module bcs_cell_model
#(
   parameter int PRE_MV = 2800,
   parameter int TRK_MV = 3000,
   parameter int REG_MV = 4200,
   parameter int RST_MV = 100
)
(
   input  var int                    vbattMv,
   input  wire logic                 srcPresent,
   input  wire logic                 srcWeak,
   input  wire logic                 taper,
   input  wire bcs_pkg::bcs_current_t currentSel,
   output logic                      sourceValid,
   output logic                      lockoutCurrent,
   output logic                      belowInputReg,
   output logic                      abovePrecharge,
   output logic                      aboveTrickle,
   output logic                      atBatteryReg,
   output logic                      belowTopoffCur,
   output logic                      belowRestart
);
   timeunit 1ns;
   timeprecision 1ps;

   assign sourceValid    = srcPresent;
   // Weak source sags and folds current down together
   assign lockoutCurrent = srcPresent & srcWeak;
   assign belowInputReg  = srcPresent & srcWeak;
   assign abovePrecharge = vbattMv > PRE_MV;
   assign aboveTrickle   = vbattMv > TRK_MV;
   assign atBatteryReg   = vbattMv >= REG_MV;
   // No current commanded reads as below top-off level
   assign belowTopoffCur = (currentSel == bcs_pkg::BCS_I_OFF) | taper;
   assign belowRestart   = vbattMv < REG_MV - RST_MV;
endmodule : bcs_cell_model

`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int PS = 4;
   localparam int PQ = 20;
   localparam int FC = 30;
   localparam int TO = 10;
   localparam int TM = 3;

   logic                  clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  ce = 1'b1;
   logic                  strap = 1'b0;
   logic                  suspend = 1'b0;
   logic                  hot = 1'b0;
   logic                  srcPresent = 1'b0;
   logic                  srcWeak = 1'b0;
   logic                  taper = 1'b0;
   int                    vbattMv = 0;
   logic                  srcOk, lockCur, lowIn, abPre, abTrk, atReg;
   logic                  lowCur, lowRst;
   bcs_pkg::bcs_state_t   state;
   bcs_pkg::bcs_current_t curSel;
   logic                  holdV, chgOn, inSw, batSys, tFlt, statOut, statOe;
   int                    n_fail = 0;
   int                    total_checks = 0;
   int                    n;

   always #4 clk = ~clk;

   bcs_charge_fsm #(
      .PRESCALE_CYCLES (PS),
      .PREQUAL_MS      (PQ),
      .FASTCHG_MS      (FC),
      .TOPOFF_MS       (TO),
      .TERM_MS         (TM)
   ) DUT (
      .clk (clk), .reset_n (reset_n), .ce (ce),
      .ironPhosphateStrap (strap), .sourceValidIn (srcOk),
      .timerSuspendIn (suspend), .lockoutCurrentIn (lockCur),
      .belowInputRegIn (lowIn), .abovePrechargeIn (abPre),
      .aboveTrickleIn (abTrk), .atBatteryRegIn (atReg),
      .belowTopoffCurIn (lowCur), .belowRestartIn (lowRst),
      .overTempIn (hot), .chargeState (state), .currentSel (curSel),
      .holdVoltage (holdV), .chargerOn (chgOn), .inputSwitchOn (inSw),
      .batterySuppliesSys (batSys), .timerFault (tFlt),
      .statOut (statOut), .statOe (statOe)
   );

   bcs_cell_model CELL (
      .vbattMv (vbattMv), .srcPresent (srcPresent), .srcWeak (srcWeak),
      .taper (taper), .currentSel (curSel), .sourceValid (srcOk),
      .lockoutCurrent (lockCur), .belowInputReg (lowIn),
      .abovePrecharge (abPre), .aboveTrickle (abTrk),
      .atBatteryReg (atReg), .belowTopoffCur (lowCur),
      .belowRestart (lowRst)
   );

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Bounded wait on the state; count gives elapsed cycles
   task automatic waitState(input bcs_pkg::bcs_state_t exp,
                            input int lim, output int cnt);
      cnt = 0;
      while (state !== exp && cnt < lim)
      begin
         @(posedge clk);
         #1;
         cnt++;
      end
      check(state, exp);
   endtask : waitState

   task automatic setBatt(input int mv);
      @(posedge clk);
      vbattMv <= mv;
   endtask : setBatt

   task automatic doReset(input int mv, input logic iron, input logic src);
      @(posedge clk);
      reset_n    <= 1'b0;
      vbattMv    <= mv;
      strap      <= iron;
      srcPresent <= 1'b0;
      srcWeak    <= 1'b0;
      taper      <= 1'b0;
      suspend    <= 1'b0;
      hot        <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      srcPresent <= src;
   endtask : doReset

   task automatic t_idle;
      doReset(0, 1'b0, 1'b0);
      repeat (20) @(posedge clk);
      #1;
      check(state, bcs_pkg::BCS_IDLE);
      check({curSel, batSys, chgOn, statOe, statOut}, 9'h008);
   endtask : t_idle

   task automatic t_liion;
      doReset(0, 1'b0, 1'b1);
      waitState(bcs_pkg::BCS_PRE, 10, n);
      check({curSel, inSw, statOe, batSys}, 9'h00E);
      setBatt(2900);
      waitState(bcs_pkg::BCS_TRK, 10, n);
      check(curSel, bcs_pkg::BCS_I_TRK);
      setBatt(3500);
      taper <= 1'b1;
      waitState(bcs_pkg::BCS_CC, 10, n);
      check(curSel, bcs_pkg::BCS_I_FAST);
      repeat (8 * TM * PS) @(posedge clk);
      #1;
      check(state, bcs_pkg::BCS_CC);
      setBatt(4200);
      waitState(bcs_pkg::BCS_CV, 10, n);
      check(holdV, 1'b1);
      waitState(bcs_pkg::BCS_TOP, (TM + 2) * PS, n);
      check(n >= (TM - 1) * PS, 1'b1);
      waitState(bcs_pkg::BCS_DONE, (TO + 2) * PS, n);
      check(n >= (TO - 1) * PS, 1'b1);
      check({curSel, holdV, chgOn}, 9'h000);
      setBatt(4050);
      waitState(bcs_pkg::BCS_CC, 10, n);
   endtask : t_liion

   task automatic t_iron;
      doReset(0, 1'b1, 1'b1);
      waitState(bcs_pkg::BCS_PRE, 10, n);
      setBatt(2900);
      repeat (6) @(posedge clk);
      #1;
      check(state, bcs_pkg::BCS_CC);
      setBatt(4200);
      taper <= 1'b1;
      waitState(bcs_pkg::BCS_CV, 10, n);
      waitState(bcs_pkg::BCS_TOP, (TM + 2) * PS, n);
      setBatt(4050);
      waitState(bcs_pkg::BCS_CC, 10, n);
   endtask : t_iron

   task automatic t_prequal;
      doReset(2900, 1'b0, 1'b1);
      waitState(bcs_pkg::BCS_TRK, 10, n);
      waitState(bcs_pkg::BCS_TFLT, (PQ + 2) * PS, n);
      check(n >= (PQ - 1) * PS, 1'b1);
      check({tFlt, chgOn, statOe, curSel}, 9'h010);
      @(posedge clk);
      suspend <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check(state, bcs_pkg::BCS_TFLT);
      @(posedge clk);
      suspend <= 1'b0;
      srcPresent <= 1'b0;
      waitState(bcs_pkg::BCS_IDLE, 10, n);
      @(posedge clk);
      srcPresent <= 1'b1;
      waitState(bcs_pkg::BCS_TRK, 10, n);
   endtask : t_prequal

   task automatic t_fastTimeout;
      doReset(3500, 1'b0, 1'b1);
      waitState(bcs_pkg::BCS_CC, 10, n);
      // Clock enable low must freeze the fast-charge timer
      @(posedge clk);
      ce <= 1'b0;
      repeat ((FC + 2) * PS) @(posedge clk);
      #1;
      check(state, bcs_pkg::BCS_CC);
      @(posedge clk);
      ce <= 1'b1;
      waitState(bcs_pkg::BCS_TFLT, (FC + 2) * PS, n);
      check(n >= (FC - 1) * PS, 1'b1);
   endtask : t_fastTimeout

   task automatic t_faults;
      doReset(3500, 1'b0, 1'b1);
      waitState(bcs_pkg::BCS_CC, 10, n);
      @(posedge clk);
      suspend <= 1'b1;
      waitState(bcs_pkg::BCS_IDLE, 10, n);
      check({chgOn, batSys}, 9'h001);
      @(posedge clk);
      suspend <= 1'b0;
      waitState(bcs_pkg::BCS_CC, 10, n);
      @(posedge clk);
      hot <= 1'b1;
      waitState(bcs_pkg::BCS_SHDN, 10, n);
      check({chgOn, statOe}, 9'h000);
      @(posedge clk);
      suspend <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check(state, bcs_pkg::BCS_SHDN);
      @(posedge clk);
      hot <= 1'b0;
      suspend <= 1'b0;
      waitState(bcs_pkg::BCS_CC, 20, n);
      @(posedge clk);
      srcWeak <= 1'b1;
      waitState(bcs_pkg::BCS_IDLE, 10, n);
      check(inSw, 1'b0);
      @(posedge clk);
      srcWeak <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      check(state, bcs_pkg::BCS_IDLE);
      @(posedge clk);
      srcPresent <= 1'b0;
      repeat (4) @(posedge clk);
      srcPresent <= 1'b1;
      waitState(bcs_pkg::BCS_CC, 10, n);
   endtask : t_faults

   task automatic stop_test;
      $display("Checks %0d, failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   initial
   begin
      repeat (5000) @(posedge clk);
      n_fail++;
      $display("ERROR at %0t: watchdog expired", $time);
      stop_test();
   end

   initial
   begin
      t_idle();
      t_liion();
      t_iron();
      t_prequal();
      t_fastTimeout();
      t_faults();
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
